// ===== fnpd_defines.svh
/*
 * Constants for the fractional divider: setting limits, decimal base and prescaler counts.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef FNPD_DEFINES_SVH
`define FNPD_DEFINES_SVH

// Offset the integer setting path adds before the modulus is decoded.
`define FNPD_INT_OFFSET    5'h02
// Lowest and highest programmed integer modulus.
`define FNPD_N_MIN         5'h0c
`define FNPD_N_MAX         5'h16
// Tenths digit limit and the decimal base of the accumulator.
`define FNPD_TENTHS_MAX    4'h9
`define FNPD_DECIMAL_BASE  5'h0a
// Last count of a prescaler cycle in divide-by-3 and divide-by-4 mode.
`define FNPD_PSC_LAST_DIV3 2'h2
`define FNPD_PSC_LAST_DIV4 2'h3
// Width of the shift register that holds the prescaler mode sequence.
`define FNPD_SEQ_BITS      8

`endif

// ===== fnpd_divider.sv
/*
 * Fractional-N programmable divider: prescaler control sequence, decimal accumulator
 * and output squaring stage.
 * Assumes clk is the divider drive and that the settings and test straps come from pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fnpd_defines.svh"

// Overview of operation
// [RQ1] Divide the drive clock by 12.1 to 22.1 in tenth steps; the code spans 12.0 to 22.9.
// [RQ2] Output pulse rate equals drive rate over the present effective modulus.
// [RQ3] Fractional ratios alternate between modulus N and N+1 across output cycles.
// [RQ4] Front end is a prescaler dividing by three or four.
// [RQ5] Prescaler mode alternates so one output cycle spans 12 to 23 inputs.
// [RQ6] Modulus 17 runs two divide-by-4 then three divide-by-3 cycles.
// [RQ7] Mode control high divides by four, low divides by three.
// [RQ8] Shift register loaded from decoded integer setting sets the mode sequence.
// [RQ9] The programmed integer setting has two added before use.
// [RQ10] Accumulator is an adder followed by a holding latch of the sum.
// [RQ11] Each output pulse adds the tenths digit to the stored sum.
// [RQ12] A carry makes the next output cycle use modulus N+1.
// [RQ13] Ratio 12.1 divides by 12 nine times, then 13 once, repeating.
// [RQ14] Modulus select flop follows the carry; high means N+1, low N.
// [RQ15] Output stage turns the narrow divider pulse into a 50% square wave; odd moduli are held low one input longer than high.
// [RQ16] Hold input forces divide-by-3 with strap low, divide-by-4 with strap high.
// [RQ17] Accumulator counts tenths modulo ten, carrying at ten and keeping the remainder.
// [RQ18] Synchronous reset clears the sum and restarts at an output cycle start.
module fnpd_divider (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Frequency select digits
	input  wire logic [4:0] integer_setting,
	input  wire logic [3:0] tenths_digit,
	// Test hold
	input  wire logic       hold_enable,
	input  wire logic       prescaler_hold_strap,
	// Outputs
	output var  logic       divided_output_point,
	output var  logic       square_output,
	output var  logic       prescaler_mode_control,
	output var  logic       modulus_select,
	output var  logic       fractional_control_signal
);

	localparam int SYNC_W = 11;
	localparam int SEQ_W  = `FNPD_SEQ_BITS;

	// Pin synchronisers; only the second stage is read by logic.
	// They are not reset, so the load during reset already sees the settled setting.
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;

	assign pins_raw = {integer_setting, tenths_digit, hold_enable, prescaler_hold_strap};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			always_ff @(posedge clk) begin
				sync1_q[gi] <= pins_raw[gi];
				sync2_q[gi] <= sync1_q[gi];
			end
		end
	endgenerate

	fnpd_pkg::fnpd_modulus_t setting_s;
	fnpd_pkg::fnpd_digit_t   tenths_s;
	logic                    hold_s;
	logic                    strap_s;

	assign setting_s = sync2_q[10:6];
	assign tenths_s  = sync2_q[5:2];
	assign hold_s    = sync2_q[1];
	assign strap_s   = sync2_q[0];

	// Integer modulus after the offset stage, clamped to the legal span.
	fnpd_pkg::fnpd_modulus_t n_base;
	fnpd_pkg::fnpd_digit_t   tenths_c;

	always_comb begin
		n_base = setting_s + `FNPD_INT_OFFSET; // [RQ9]
		if (setting_s > (`FNPD_N_MAX - `FNPD_INT_OFFSET)) begin
			n_base = `FNPD_N_MAX;
		end else if (n_base < `FNPD_N_MIN) begin
			n_base = `FNPD_N_MIN;
		end
		// An illegal tenths code is treated as nine so the sum stays decimal.
		tenths_c = (tenths_s > `FNPD_TENTHS_MAX) ? `FNPD_TENTHS_MAX : tenths_s;
	end

	// Decoder: a modulus M is split into M/3 prescaler cycles, of which the
	// first M mod 3 divide by four. This covers 12 to 23 with one table.
	function automatic logic [SEQ_W-1:0] seq_pattern(input fnpd_pkg::fnpd_modulus_t m);
		logic [SEQ_W-1:0] p;
		fnpd_pkg::fnpd_modulus_t r;
		p = '0;
		r = m % 5'h03;
		for (int i = 0; i < 3; i++) begin
			if (5'(i) < r) begin
				p[i] = 1'b1; // [RQ6]
			end
		end
		return p;
	endfunction

	function automatic fnpd_pkg::fnpd_count_t seq_length(input fnpd_pkg::fnpd_modulus_t m);
		fnpd_pkg::fnpd_modulus_t q;
		q = m / 5'h03;
		return q[2:0];
	endfunction

	// Prescaler.
	logic                     psc_tick;
	fnpd_pkg::fnpd_psc_mode_t mode_q;
	fnpd_pkg::fnpd_psc_mode_t mode_d;

	fnpd_prescaler u_prescaler ( // [RQ4] [RQ7]
		.clk                    (clk),
		.reset                  (reset),
		.prescaler_mode_control (mode_q),
		.prescaler_tick         (psc_tick)
	);

	// Sequence, accumulator and output state.
	logic [SEQ_W-1:0]        shift_q;
	logic [SEQ_W-1:0]        shift_d;
	fnpd_pkg::fnpd_count_t   left_q;
	fnpd_pkg::fnpd_count_t   left_d;
	fnpd_pkg::fnpd_digit_t   acc_q;
	fnpd_pkg::fnpd_digit_t   acc_d;
	fnpd_pkg::fnpd_modulus_t mod_q;
	fnpd_pkg::fnpd_modulus_t mod_d;
	fnpd_pkg::fnpd_modulus_t phase_q;
	fnpd_pkg::fnpd_modulus_t phase_d;
	logic                    carry_q;
	logic                    carry_d;
	logic                    pulse_q;
	logic                    pulse_d;
	logic                    frac_q;
	logic                    frac_d;
	logic                    square_q;
	logic                    square_d;

	fnpd_pkg::fnpd_modulus_t sum;
	fnpd_pkg::fnpd_modulus_t next_mod;
	logic [SEQ_W-1:0]        pattern;
	logic [SEQ_W-1:0]        start_pattern;
	logic                    cycle_end;
	logic                    carry_now;
	fnpd_pkg::fnpd_psc_mode_t seq_mode;

	always_comb begin
		cycle_end = psc_tick && (left_q == 3'h1); // [RQ5]
		// Adder in front of the holding register; a decimal carry at ten.
		sum       = {1'b0, acc_q} + {1'b0, tenths_c}; // [RQ10]
		carry_now = (sum >= `FNPD_DECIMAL_BASE); // [RQ17]
		next_mod  = n_base + {4'h0, carry_now}; // [RQ12]
		pattern   = seq_pattern(next_mod);
		start_pattern = seq_pattern(n_base);

		shift_d  = shift_q;
		left_d   = left_q;
		acc_d    = acc_q;
		mod_d    = mod_q;
		carry_d  = carry_q;
		pulse_d  = 1'b0;
		frac_d   = 1'b0;
		seq_mode = fnpd_pkg::fnpd_psc_mode_t'(shift_q[0]);
		phase_d  = phase_q + 5'h01;

		if (reset) begin
			// Restart with an empty sum at the first prescaler cycle of modulus N.
			acc_d    = 4'h0; // [RQ18]
			carry_d  = 1'b0;
			mod_d    = n_base;
			shift_d  = start_pattern >> 1;
			left_d   = seq_length(n_base);
			seq_mode = fnpd_pkg::fnpd_psc_mode_t'(start_pattern[0]);
			phase_d  = 5'h00;
		end else if (cycle_end) begin
			// Each output pulse adds the tenths digit and reloads the sequence.
			acc_d    = carry_now ? 4'(sum - `FNPD_DECIMAL_BASE) : sum[3:0]; // [RQ11] [RQ17]
			carry_d  = carry_now; // [RQ14]
			frac_d   = carry_now;
			mod_d    = next_mod; // [RQ3] [RQ13]
			shift_d  = pattern >> 1; // [RQ8]
			left_d   = seq_length(next_mod);
			seq_mode = fnpd_pkg::fnpd_psc_mode_t'(pattern[0]);
			pulse_d  = 1'b1; // [RQ2] [RQ1]
			phase_d  = 5'h00;
		end else if (psc_tick) begin
			shift_d  = shift_q >> 1; // [RQ8]
			left_d   = left_q - 3'h1;
			seq_mode = fnpd_pkg::fnpd_psc_mode_t'(shift_q[0]);
		end else begin
			seq_mode = mode_q;
		end

		// The strap overrides the sequence but the cycle count keeps running.
		if (hold_s) begin
			mode_d = strap_s ? fnpd_pkg::FNPD_DIV4 : fnpd_pkg::FNPD_DIV3; // [RQ16]
		end else begin
			mode_d = seq_mode; // [RQ5]
		end

		// High for the first half of the cycle; odd moduli give the extra input low.
		square_d = (phase_d < (mod_d >> 1)); // [RQ15]
	end

	always_ff @(posedge clk) begin
		shift_q  <= shift_d;
		left_q   <= left_d;
		acc_q    <= acc_d;
		mod_q    <= mod_d;
		phase_q  <= phase_d;
		carry_q  <= carry_d;
		pulse_q  <= pulse_d;
		frac_q   <= frac_d;
		square_q <= square_d;
		mode_q   <= mode_d;
	end

	assign divided_output_point      = pulse_q;
	assign square_output             = square_q;
	assign prescaler_mode_control    = mode_q;
	assign modulus_select            = carry_q;
	assign fractional_control_signal = frac_q;

endmodule

`default_nettype wire

// ===== fnpd_divider_chk.sv
/* Port checker for the fractional divider.
   Assumes it is bound to fnpd_divider on one clock. */
`timescale 1ns/1ns
`default_nettype none
module fnpd_divider_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// Settings
	input wire logic [4:0] integer_setting,
	input wire logic [3:0] tenths_digit,
	input wire logic       hold_enable,
	input wire logic       prescaler_hold_strap,
	// Outputs
	input wire logic       divided_output_point,
	input wire logic       square_output,
	input wire logic       prescaler_mode_control,
	input wire logic       modulus_select,
	input wire logic       fractional_control_signal
);
	logic [4:0] gap_q;
	logic [4:0] gap_d;
	// Cleared in reset; the first cycle after reset then reads one more than a normal one.
	always_comb begin
		gap_d = (gap_q == 5'h1f) ? gap_q : gap_q + 5'h01;
		if (reset) begin
			gap_d = 5'h00;
		end else if (divided_output_point) begin
			gap_d = 5'h00;
		end
	end
	always_ff @(posedge clk) begin
		gap_q <= gap_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_pulse_one_cycle: assert property (divided_output_point |=> !divided_output_point)
		else $error("output pulse too long");
	chk_gap_min: assert property (divided_output_point |-> gap_q >= 5'h0b)
		else $error("output cycle shorter than 12");
	chk_gap_max: assert property (gap_q <= 5'h1b)
		else $error("output cycle too long");
	chk_carry_with_pulse: assert property (fractional_control_signal |-> divided_output_point)
		else $error("carry without output pulse");
	chk_select_on_carry: assert property (divided_output_point && fractional_control_signal |=> modulus_select)
		else $error("select low after carry");
	chk_select_no_carry: assert property (divided_output_point && !fractional_control_signal |=> !modulus_select)
		else $error("select high without carry");
	chk_hold_div4: assert property ((hold_enable && prescaler_hold_strap)[*8] |-> prescaler_mode_control)
		else $error("hold high not divide by 4");
	chk_hold_div3: assert property ((hold_enable && !prescaler_hold_strap)[*8] |-> !prescaler_mode_control)
		else $error("hold low not divide by 3");
	chk_square_high: assert property ($rose(square_output) |-> square_output[*6])
		else $error("square high phase short");
	chk_zero_no_carry: assert property ((tenths_digit == 4'h0)[*8] |-> !fractional_control_signal)
		else $error("carry with zero tenths");
	cov_carry: cover property (fractional_control_signal);
	cov_hold4: cover property (hold_enable && prescaler_hold_strap && prescaler_mode_control);
	cov_square: cover property ($fell(square_output));
endmodule
bind fnpd_divider fnpd_divider_chk i_chk (.clk, .reset, .integer_setting, .tenths_digit,
	.hold_enable, .prescaler_hold_strap, .divided_output_point, .square_output,
	.prescaler_mode_control, .modulus_select, .fractional_control_signal);
`default_nettype wire

// ===== fnpd_divider_tb.sv
/* Self-checking bench for fnpd_divider with a detector model.
   Assumes nothing outside these files. */
`timescale 1ns/1ns
`default_nettype none
module fnpd_divider_tb;
	logic       clk;
	logic       reset;
	logic [4:0] integer_setting;
	logic [3:0] tenths_digit;
	logic       hold_enable;
	logic       prescaler_hold_strap;
	logic       divided_output_point;
	logic       square_output;
	logic       prescaler_mode_control;
	logic       modulus_select;
	logic       fractional_control_signal;
	logic [5:0] period_len;
	logic       period_carry;
	logic       period_seen;
	int         fails;
	int         tests_run;
	int         cycle_count;
	localparam logic [4:0] CODES [7] = '{5'h0a, 5'h0f, 5'h14, 5'h0d, 5'h12, 5'h1f, 5'h03};
	localparam logic [3:0] TENS [7] = '{4'h0, 4'h0, 4'h9, 4'h5, 4'h3, 4'hf, 4'h1};
	fnpd_divider i_dut (.clk, .reset, .integer_setting, .tenths_digit, .hold_enable,
		.prescaler_hold_strap, .divided_output_point, .square_output,
		.prescaler_mode_control, .modulus_select, .fractional_control_signal);
	fnpd_pd_model i_pd (.clk, .reset, .divided_output_point, .fractional_control_signal,
		.period_len, .period_carry, .period_seen);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task test_done;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task check(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task get_period(output logic [5:0] len, output logic carry);
		do @(negedge clk); while (period_seen !== 1'b1);
		len = period_len;
		carry = period_carry;
	endtask
	task do_reset;
		@(negedge clk);
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
	endtask
	task t_ratio_table;
		logic [5:0] len;
		logic       c;
		logic [7:0] sum;
		logic [7:0] n;
		logic [7:0] t;
		for (int i = 0; i < 7; i++) begin
			@(negedge clk);
			integer_setting = CODES[i];
			tenths_digit = TENS[i];
			repeat (3) get_period(len, c);
			sum = 8'h00;
			repeat (10) begin
				get_period(len, c);
				sum = sum + {2'h0, len};
			end
			n = {3'h0, CODES[i]} + 8'h02;
			n = (n > 8'h16) ? 8'h16 : n;
			n = (n < 8'h0c) ? 8'h0c : n;
			t = (TENS[i] > 4'h9) ? 8'h09 : {4'h0, TENS[i]};
			check("cycles_per_ten_outputs", n * 8'h0a + t, sum);
		end
	endtask
	task t_hold;
		logic [5:0] len;
		logic       c;
		@(negedge clk);
		integer_setting = 5'h0f;
		tenths_digit = 4'h0;
		hold_enable = 1'b1;
		for (int s = 0; s < 2; s++) begin
			@(negedge clk);
			prescaler_hold_strap = s[0];
			repeat (4) get_period(len, c);
			check("hold_period", s[0] ? 8'h14 : 8'h0f, {2'h0, len});
			check("prescaler_mode", {7'h00, s[0]}, {7'h00, prescaler_mode_control});
		end
		hold_enable = 1'b0;
	endtask
	// Modulus 17 is left from the hold test, so the high phase is eight input cycles.
	task t_square;
		logic [5:0] len;
		logic       c;
		logic [7:0] hi;
		repeat (4) get_period(len, c);
		hi = 8'h00;
		do begin
			@(negedge clk);
			if (square_output === 1'b1) hi = hi + 8'h01;
		end while (period_seen !== 1'b1);
		check("square_high_cycles", 8'h08, hi);
	endtask
	task t_reset_carry;
		logic [5:0] len;
		logic       c;
		logic       prev;
		logic [7:0] first;
		@(negedge clk);
		integer_setting = 5'h0a;
		tenths_digit = 4'h1;
		do_reset;
		first = 8'h00;
		get_period(len, prev);
		for (int i = 2; i <= 20; i++) begin
			get_period(len, c);
			check("period", prev ? 8'h0d : 8'h0c, {2'h0, len});
			check("modulus_select", (i % 10 == 0) ? 8'h01 : 8'h00, {7'h00, modulus_select});
			if (c === 1'b1 && first == 8'h00) first = 8'(i);
			prev = c;
		end
		check("first_carry_pulse", 8'h0a, first);
	endtask
	// A hang anywhere ends the run as a failure.
	always @(posedge clk) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 6000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		reset = 1'b1;
		integer_setting = 5'h0a;
		tenths_digit = 4'h0;
		hold_enable = 1'b0;
		prescaler_hold_strap = 1'b0;
		fails = 0;
		tests_run = 0;
		cycle_count = 0;
		do_reset;
		t_ratio_table;
		t_hold;
		t_square;
		t_reset_carry;
		test_done;
	end
endmodule
`default_nettype wire

// ===== fnpd_pd_model.sv
/* Phase detector side model: measures each output cycle in drive cycles.
   Assumes the drive clock is clk. */
`timescale 1ns/1ns
`default_nettype none
module fnpd_pd_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Divider outputs
	input  wire logic       divided_output_point,
	input  wire logic       fractional_control_signal,
	// Last measured cycle
	output var  logic [5:0] period_len,
	output var  logic       period_carry,
	output var  logic       period_seen
);
	logic [5:0] cnt_q;
	// The first length after reset is one drive cycle too long and must be discarded.
	always_ff @(posedge clk) begin
		cnt_q <= (reset || divided_output_point) ? 6'h01 : cnt_q + 6'h01;
		period_seen <= divided_output_point && !reset;
		if (divided_output_point) begin
			period_len <= cnt_q;
			period_carry <= fractional_control_signal;
		end
	end
endmodule
`default_nettype wire

// ===== fnpd_pkg.sv
/*
 * Types shared by the fractional divider modules.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package fnpd_pkg;

	typedef enum logic {
		FNPD_DIV3 = 1'b0,
		FNPD_DIV4 = 1'b1
	} fnpd_psc_mode_t;

	typedef logic [4:0] fnpd_modulus_t;
	typedef logic [3:0] fnpd_digit_t;
	typedef logic [2:0] fnpd_count_t;

endpackage

`default_nettype wire

// ===== fnpd_prescaler.sv
/*
 * Dual-modulus prescaler that divides the drive clock by three or four.
 * Assumes the mode input is registered on the same clock and changes only after a tick.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fnpd_defines.svh"

module fnpd_prescaler (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// Mode and divided tick
	input  wire fnpd_pkg::fnpd_psc_mode_t prescaler_mode_control,
	output var  logic                    prescaler_tick
);

	logic [1:0] count_q;
	logic [1:0] count_d;
	logic [1:0] last_count;

	always_comb begin
		// Mode high divides by four, low by three.
		if (prescaler_mode_control == fnpd_pkg::FNPD_DIV4) begin // [RQ7]
			last_count = `FNPD_PSC_LAST_DIV4;
		end else begin
			last_count = `FNPD_PSC_LAST_DIV3;
		end
		prescaler_tick = (count_q == last_count); // [RQ4]
		if (reset || prescaler_tick) begin
			count_d = 2'h0;
		end else begin
			count_d = count_q + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		count_q <= count_d;
	end

endmodule

`default_nettype wire
